/* src/tfcs_top.v */
//
// Operation
// - rewind is command 07 with go, accepted only while drive ready is set.
// - rewind drops drive ready one cycle, raises it once passed to transport.
// - command 11 with go clears this formatter's own state, and also pulses drive_clear and, if busy, motion_stop.
// - rewind done gives slave change, attention, clears positioning, shows beginning of tape.
// - attention sets at once if ready, else as soon as ready returns.
// - status bit 14 mirrors any error; bit 6 sets on transport status change.
// - bit 12 shows medium online; bit 11 write lock, which blocks all writes.
// - bit 7 shows drive ready; bit 1 shows tape at beginning marker.
// - tape control bit 3 set selects even parity in NRZI, clear selects odd.
// - phase encoded density always uses odd character parity.
// - tape control holds format in bits 4-7, density in bits 8-10.
// - write record is command 61 with go, after counts are loaded.
// - write frame count is two or four characters per 16-bit word.
// - after a write, status bit 4 follows phase encoded density selection.
// - read forward is command 71 with go, no frame count load needed.
// - frame count clears itself when a read transfer starts.
// - space ends on frame count overflow, or beginning, end, or tape mark.
// - command 27 with go writes tape mark; status bit 2 shows mark seen.
// - drive type shows bit 14 for tape and fixed code in bits 0-7.
// - drive type bit 10 shows selected transport present.
`timescale 1ns/10ps
`include "tfcs_map.vh"

module tfcs_top
#(
    parameter [7:0]  TYPE_CODE  = 8'h5A,  // arbitrary neutral type code
    parameter [2:0]  PE_DENSITY = `TFCS_DEN_PE,
    parameter        FC_W       = 16,
    parameter        CHAR_W     = 8
)
(
    input  wire                   ref_clk,
    input  wire                   rst_b,
    input  wire                   cmd_wr,
    input  wire [`TFCS_CMD_W-1:0] cmd_word,
    input  wire                   tc_wr,
    input  wire [15:0]            tc_wdata,
    input  wire                   fc_wr,
    input  wire [FC_W-1:0]        fc_wdata,
    input  wire                   ata_clr,
    input  wire [15:0]            err_flags,
    input  wire [CHAR_W-1:0]      wr_char,
    input  wire                   tp_present,
    input  wire                   tp_online,
    input  wire                   tp_wlock,
    input  wire                   tp_bot,
    input  wire                   tp_eot,
    input  wire                   tp_mark,
    input  wire                   tp_frame,
    input  wire                   tp_gap,
    input  wire                   tp_rew_done,
    output reg  [15:0]            drive_status,
    output reg  [15:0]            drive_type,
    output reg  [15:0]            tape_control,
    output reg  [FC_W-1:0]        frame_count,
    output reg                    attention_line,
    output reg  [`TFCS_OP_W-1:0]  motion_op,
    output reg                    motion_go,
    output reg                    motion_stop,
    output reg                    drive_clear,
    output wire                   char_parity
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_REW   = 3'h1;
    localparam [2:0] ST_WRITE = 3'h2;
    localparam [2:0] ST_READ  = 3'h3;
    localparam [2:0] ST_SPACE = 3'h4;
    localparam [2:0] ST_MARK  = 3'h5;

    wire [`TFCS_TP_W-1:0] tp_s;
    reg  [`TFCS_TP_W-1:0] tp_d_r;
    wire [`TFCS_TP_W-1:0] tp_rise;

    reg  [2:0]            state_r;
    reg  [2:0]            state_nxt;
    reg                   dry_r;
    reg                   pip_r;
    reg                   ssc_r;
    reg                   ata_r;
    reg                   ata_pend_r;
    reg                   tm_r;
    reg                   idb_r;
    reg                   rev_r;
    reg  [FC_W-1:0]       fc_r;
    reg  [FC_W-1:0]       fc_nxt;
    reg                   go_nxt;
    reg                   stop_nxt;
    reg  [`TFCS_OP_W-1:0] op_nxt;

    wire                  dclr_cmd;
    wire                  go_ok;
    wire                  pe_mode;
    wire                  any_err;
    wire [FC_W-1:0]       fc_inc;
    wire [FC_W-1:0]       fc_dec;
    wire                  status_change;

    // transport pins are asynchronous to ref_clk
    tfcs_sync
    #(
        .WIDTH    (`TFCS_TP_W)
    )
    u_sync
    (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in ({tp_rew_done, tp_gap, tp_frame, tp_mark, tp_eot,
                    tp_bot, tp_wlock, tp_online, tp_present}),
        .sync_out (tp_s)
    );

    // edge history taken from the synchronised side only
    always @(posedge ref_clk)
    begin
        if (!rst_b)
            tp_d_r <= {`TFCS_TP_W{1'b0}};
        else
            tp_d_r <= tp_s;
    end

    assign tp_rise = tp_s & ~tp_d_r;

    // phase encoded forces odd parity over the select bit
    assign pe_mode = (tape_control[`TFCS_TC_DEN_MSB:`TFCS_TC_DEN_LSB] == PE_DENSITY);

    tfcs_parity
    #(
        .WIDTH      (CHAR_W)
    )
    u_parity
    (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .char_in    (wr_char),
        .even_sel   (tape_control[`TFCS_TC_EVEN] & ~pe_mode),
        .parity_out (char_parity)
    );

    // drive clear is taken in any state so a hung operation can be undone
    assign dclr_cmd      = cmd_wr && (cmd_word == `TFCS_CMD_DCLR);
    assign go_ok         = cmd_wr && cmd_word[0] && dry_r;
    assign any_err       = |err_flags;
    assign fc_inc        = fc_r + {{(FC_W-1){1'b0}}, 1'b1};
    assign fc_dec        = fc_r - {{(FC_W-1){1'b0}}, 1'b1};
    assign status_change = tp_rise[`TFCS_TP_REWDONE] && pip_r;

    // command decode and operation sequencing
    always @*
    begin
        state_nxt = state_r;
        fc_nxt    = fc_r;
        go_nxt    = 1'b0;
        stop_nxt  = 1'b0;
        op_nxt    = motion_op;
        case (state_r)
            ST_IDLE:
            begin
                if (fc_wr)
                    fc_nxt = fc_wdata;
                if (go_ok && !dclr_cmd)
                begin
                    if (cmd_word == `TFCS_CMD_REWIND)
                    begin
                        state_nxt = ST_REW;
                        op_nxt    = `TFCS_OP_REWIND;
                        go_nxt    = 1'b1;
                    end
                    else if (cmd_word == `TFCS_CMD_WRITE && !tp_s[`TFCS_TP_WLOCK])
                    begin
                        state_nxt = ST_WRITE;
                        op_nxt    = `TFCS_OP_WRITE;
                        go_nxt    = 1'b1;
                    end
                    else if (cmd_word == `TFCS_CMD_MARK && !tp_s[`TFCS_TP_WLOCK])
                    begin
                        state_nxt = ST_MARK;
                        op_nxt    = `TFCS_OP_MARK;
                        go_nxt    = 1'b1;
                    end
                    else if (cmd_word == `TFCS_CMD_READ_FWD || cmd_word == `TFCS_CMD_READ_REV)
                    begin
                        state_nxt = ST_READ;
                        fc_nxt    = {FC_W{1'b0}};
                        op_nxt    = (cmd_word == `TFCS_CMD_READ_REV) ? `TFCS_OP_READ_REV
                                                                     : `TFCS_OP_READ_FWD;
                        go_nxt    = 1'b1;
                    end
                    else if (cmd_word == `TFCS_CMD_SPACE_FWD || cmd_word == `TFCS_CMD_SPACE_REV)
                    begin
                        state_nxt = ST_SPACE;
                        op_nxt    = (cmd_word == `TFCS_CMD_SPACE_REV) ? `TFCS_OP_SPACE_REV
                                                                      : `TFCS_OP_SPACE_FWD;
                        go_nxt    = 1'b1;
                    end
                end
            end
            ST_REW:
            begin
                // request already passed to the transport: ready again
                state_nxt = ST_IDLE;
            end
            ST_WRITE:
            begin
                // one character per frame strobe, host sized the count
                if (tp_rise[`TFCS_TP_FRAME])
                begin
                    fc_nxt = fc_dec;
                    if (fc_r == {{(FC_W-1){1'b0}}, 1'b1})
                    begin
                        state_nxt = ST_IDLE;
                        stop_nxt  = 1'b1;
                    end
                end
            end
            ST_READ:
            begin
                if (tp_rise[`TFCS_TP_FRAME])
                    fc_nxt = fc_inc;
                if (tp_rise[`TFCS_TP_GAP] || (rev_r && tp_rise[`TFCS_TP_BOT]))
                begin
                    state_nxt = ST_IDLE;
                    stop_nxt  = 1'b1;
                end
            end
            ST_SPACE:
            begin
                // count records up from the negated value towards zero
                if (tp_rise[`TFCS_TP_GAP])
                    fc_nxt = fc_inc;
                if ((tp_rise[`TFCS_TP_GAP] && fc_inc == {FC_W{1'b0}}) ||
                    tp_rise[`TFCS_TP_BOT] || tp_rise[`TFCS_TP_EOT] ||
                    tp_rise[`TFCS_TP_MARK])
                begin
                    state_nxt = ST_IDLE;
                    stop_nxt  = 1'b1;
                end
            end
            ST_MARK:
            begin
                if (tp_rise[`TFCS_TP_MARK])
                begin
                    state_nxt = ST_IDLE;
                    stop_nxt  = 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (dclr_cmd)
        begin
            state_nxt = ST_IDLE;
            stop_nxt  = (state_r != ST_IDLE);
        end
    end

    // sequencer registers and transport requests
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_r     <= ST_IDLE;
            fc_r        <= `TFCS_FC_RESET;
            motion_op   <= {`TFCS_OP_W{1'b0}};
            motion_go   <= 1'b0;
            motion_stop <= 1'b0;
            drive_clear <= 1'b0;
            rev_r       <= 1'b0;
            dry_r       <= 1'b1;
        end
        else
        begin
            state_r     <= state_nxt;
            fc_r        <= fc_nxt;
            motion_op   <= op_nxt;
            motion_go   <= go_nxt;
            motion_stop <= stop_nxt;
            drive_clear <= dclr_cmd;
            if (go_nxt)
                rev_r <= (op_nxt == `TFCS_OP_READ_REV);
            dry_r       <= (state_nxt == ST_IDLE);
        end
    end

    // positioning, slave change and attention; a set wins over a clear, except that rewind done clearing positioning wins over a new rewind
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            pip_r      <= 1'b0;
            ssc_r      <= 1'b0;
            ata_r      <= 1'b0;
            ata_pend_r <= 1'b0;
        end
        else
        begin
            if (status_change)
                pip_r <= 1'b0;
            else if (state_r == ST_IDLE && state_nxt == ST_REW)
                pip_r <= 1'b1;
            else if (dclr_cmd)
                pip_r <= 1'b0;

            if (status_change)
                ssc_r <= 1'b1;
            else if (dclr_cmd)
                ssc_r <= 1'b0;

            // attention held off while busy, raised when ready returns
            if ((status_change || ata_pend_r) && dry_r)
                ata_r <= 1'b1;
            else if (dclr_cmd || ata_clr)
                ata_r <= 1'b0;

            if (status_change && !dry_r)
                ata_pend_r <= 1'b1;
            else if (dry_r || dclr_cmd)
                ata_pend_r <= 1'b0;
        end
    end

    // tape mark seen and encoding of the last written record
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            tm_r  <= 1'b0;
            idb_r <= 1'b0;
        end
        else
        begin
            if (tp_rise[`TFCS_TP_MARK])
                tm_r <= 1'b1;
            else if (dclr_cmd || go_nxt)
                tm_r <= 1'b0;

            if (state_r == ST_WRITE && state_nxt == ST_IDLE && !dclr_cmd)
                idb_r <= pe_mode;
            else if (dclr_cmd)
                idb_r <= 1'b0;
        end
    end

    // tape control held while busy so a transfer sees stable fields
    always @(posedge ref_clk)
    begin
        if (!rst_b)
            tape_control <= `TFCS_TC_RESET;
        else if (tc_wr && dry_r)
            tape_control <= tc_wdata & `TFCS_TC_MASK;
    end

    // host-visible images, all registered
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            drive_status   <= 16'h0000;
            drive_type     <= 16'h0000;
            frame_count    <= `TFCS_FC_RESET;
            attention_line <= 1'b0;
        end
        else
        begin
            drive_status                  <= 16'h0000;
            drive_status[`TFCS_DS_ATA]    <= ata_r;
            drive_status[`TFCS_DS_ERR]    <= any_err;
            drive_status[`TFCS_DS_PIP]    <= pip_r;
            drive_status[`TFCS_DS_MOL]    <= tp_s[`TFCS_TP_ONLINE];
            drive_status[`TFCS_DS_WRL]    <= tp_s[`TFCS_TP_WLOCK];
            drive_status[`TFCS_DS_EOT]    <= tp_s[`TFCS_TP_EOT];
            drive_status[`TFCS_DS_DRY]    <= dry_r;
            drive_status[`TFCS_DS_SSC]    <= ssc_r;
            drive_status[`TFCS_DS_IDB]    <= idb_r;
            drive_status[`TFCS_DS_TM]     <= tm_r;
            drive_status[`TFCS_DS_BOT]    <= tp_s[`TFCS_TP_BOT];
            drive_type                    <= 16'h0000;
            drive_type[`TFCS_DT_TAPE]     <= 1'b1;
            drive_type[`TFCS_DT_SPR]      <= tp_s[`TFCS_TP_PRESENT];
            drive_type[`TFCS_DT_CODE_MSB:0] <= TYPE_CODE;
            frame_count                   <= fc_r;
            attention_line                <= ata_r;
        end
    end

endmodule

/* include/tfcs_map.vh */
`ifndef TFCS_MAP_VH
`define TFCS_MAP_VH

// command words as seen on the command port, go bit in bit 0
`define TFCS_CMD_W          6
`define TFCS_CMD_REWIND     6'h07
`define TFCS_CMD_DCLR       6'h09
`define TFCS_CMD_MARK       6'h17
`define TFCS_CMD_SPACE_FWD  6'h19
`define TFCS_CMD_SPACE_REV  6'h1B
`define TFCS_CMD_WRITE      6'h31
`define TFCS_CMD_READ_FWD   6'h39
`define TFCS_CMD_READ_REV   6'h3F

// motion requests towards the transport
`define TFCS_OP_W           3
`define TFCS_OP_REWIND      3'h1
`define TFCS_OP_WRITE       3'h2
`define TFCS_OP_READ_FWD    3'h3
`define TFCS_OP_READ_REV    3'h4
`define TFCS_OP_SPACE_FWD   3'h5
`define TFCS_OP_SPACE_REV   3'h6
`define TFCS_OP_MARK        3'h7

// drive status bit positions
`define TFCS_DS_ATA         15
`define TFCS_DS_ERR         14
`define TFCS_DS_PIP         13
`define TFCS_DS_MOL         12
`define TFCS_DS_WRL         11
`define TFCS_DS_EOT         10
`define TFCS_DS_DRY         7
`define TFCS_DS_SSC         6
`define TFCS_DS_IDB         4
`define TFCS_DS_TM          2
`define TFCS_DS_BOT         1

// drive type bit positions
`define TFCS_DT_TAPE        14
`define TFCS_DT_SPR         10
`define TFCS_DT_CODE_MSB    7

// tape control field positions and reset value
`define TFCS_TC_SEL_MSB     2
`define TFCS_TC_EVEN        3
`define TFCS_TC_FMT_LSB     4
`define TFCS_TC_FMT_MSB     7
`define TFCS_TC_DEN_LSB     8
`define TFCS_TC_DEN_MSB     10
`define TFCS_TC_MASK        16'h07FF
`define TFCS_TC_RESET       16'h0000

// density code taken as phase encoded, and frame count reset value
`define TFCS_DEN_PE         3'h4
`define TFCS_FC_RESET       16'h0000

// transport input bit positions in the synchronised bundle
`define TFCS_TP_W           9
`define TFCS_TP_PRESENT     0
`define TFCS_TP_ONLINE      1
`define TFCS_TP_WLOCK       2
`define TFCS_TP_BOT         3
`define TFCS_TP_EOT         4
`define TFCS_TP_MARK        5
`define TFCS_TP_FRAME       6
`define TFCS_TP_GAP         7
`define TFCS_TP_REWDONE     8

`endif

/* src/tfcs_sync.v */
`timescale 1ns/10ps
// two stage synchroniser for a bundle of independent levels
module tfcs_sync
#(
    parameter WIDTH = 1
)
(
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            meta_r   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

/* src/tfcs_parity.v */
`timescale 1ns/10ps
// character parity bit, registered
module tfcs_parity
#(
    parameter WIDTH = 8
)
(
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] char_in,
    input  wire             even_sel,
    output reg              parity_out
);

    // even parity: bit makes total count even; odd: makes it odd
    always @(posedge ref_clk)
    begin
        if (!rst_b)
            parity_out <= 1'b0;
        else
            parity_out <= (^char_in) ^ ~even_sel;
    end

endmodule

/* tb/tfcs_top_sva.sv */
`timescale 1ns/10ps
`include "tfcs_map.vh"
// port-level watch on the formatter; sees only the top ports
module tfcs_top_sva
#(
    parameter [7:0] TYPE_CODE  = 8'h5A,
    parameter [2:0] PE_DENSITY = 3'h4
)
(
    input wire                   ref_clk,
    input wire                   rst_b,
    input wire                   cmd_wr,
    input wire [`TFCS_CMD_W-1:0] cmd_word,
    input wire                   tc_wr,
    input wire [15:0]            err_flags,
    input wire [7:0]             wr_char,
    input wire                   tp_present,
    input wire [15:0]            drive_status,
    input wire [15:0]            drive_type,
    input wire [15:0]            tape_control,
    input wire [15:0]            frame_count,
    input wire                   attention_line,
    input wire [`TFCS_OP_W-1:0]  motion_op,
    input wire                   motion_go,
    input wire                   char_parity
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ready drops one status cycle, then comes back while the tape still moves
    sequence s_ready_blip;
        !drive_status[`TFCS_DS_DRY] ##1 drive_status[`TFCS_DS_DRY];
    endsequence

    chk_rew_blip: assert property (motion_go && motion_op == `TFCS_OP_REWIND |=> s_ready_blip)
        else $error("ready did not blip after rewind");
    chk_go_cause: assert property (motion_go |-> $past(cmd_wr) && $past(cmd_word[0]))
        else $error("motion start without a go command");
    chk_type_fixed: assert property ($past(rst_b) |-> drive_type[`TFCS_DT_TAPE] && drive_type[7:0] == TYPE_CODE)
        else $error("drive type code wrong");
    chk_spr_follow: assert property (tp_present [*4] |=> drive_type[`TFCS_DT_SPR])
        else $error("present transport not shown");
    chk_err_mirror: assert property ((err_flags != 16'h0000) [*3] |=> drive_status[`TFCS_DS_ERR])
        else $error("error summary bit missing");
    chk_atn_line: assert property (attention_line == drive_status[`TFCS_DS_ATA])
        else $error("attention line differs from status");
    chk_wlock_block: assert property (motion_go && $past(drive_status[11]) && $past(drive_status[11], 2)
        |-> motion_op != `TFCS_OP_WRITE && motion_op != `TFCS_OP_MARK)
        else $error("write started while locked");
    chk_parity_sel: assert property ($past(rst_b) |-> char_parity ==
        (($past(tape_control[3]) && $past(tape_control[10:8]) != PE_DENSITY) ? ^$past(wr_char) : ~^$past(wr_char)))
        else $error("character parity wrong");
    chk_read_clear: assert property (motion_go && motion_op == `TFCS_OP_READ_FWD |-> ##[0:1] frame_count == 16'h0000)
        else $error("frame count not cleared on read");
    chk_tc_write: assert property (!$stable(tape_control) |-> $past(tc_wr))
        else $error("tape control changed without a write");
endmodule

bind tfcs_top tfcs_top_sva #(.TYPE_CODE(TYPE_CODE), .PE_DENSITY(PE_DENSITY)) u_sva
(
    .ref_clk, .rst_b, .cmd_wr, .cmd_word, .tc_wr, .err_flags, .wr_char, .tp_present, .drive_status,
    .drive_type, .tape_control, .frame_count, .attention_line, .motion_op, .motion_go, .char_parity
);

/* tb/tfcs_transport_model.sv */
`timescale 1ns/10ps
`include "tfcs_map.vh"
// transport stand-in: answers each motion request with tape events
module tfcs_transport_model
(
    input  wire       ref_clk,
    input  wire [2:0] motion_op,
    input  wire       motion_go,
    input  wire       motion_stop,
    input  wire [3:0] pace,
    input  wire [3:0] read_len,
    output reg        tp_bot,
    output reg  [3:0] tp_ev
);
    reg     stopped;
    integer n;

    // a stop pulse from the formatter ends an open-ended stream
    always @(posedge ref_clk)
        stopped <= motion_go ? 1'b0 : (stopped | motion_stop);

    // event held two cycles so the two-stage synchroniser cannot miss it
    task pulse(input integer b);
    begin
        tp_ev[b] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        tp_ev[b] <= 1'b0;
        repeat (pace + 2) @(posedge ref_clk);
    end
    endtask

    // bits: 0 frame, 1 record gap, 2 tape mark, 3 rewind done
    initial
    begin
        tp_bot = 1'b0;
        tp_ev  = 4'h0;
        forever
        begin
            @(posedge ref_clk);
            if (motion_go)
            begin
                repeat (pace) @(posedge ref_clk);
                tp_bot <= 1'b0;
                n = 0;
                if (motion_op == `TFCS_OP_REWIND)
                begin
                    tp_bot <= 1'b1;
                    pulse(3);
                end
                else if (motion_op == `TFCS_OP_MARK)
                    pulse(2);
                else if (motion_op == `TFCS_OP_READ_FWD)
                begin
                    for (n = 0; n < read_len; n = n + 1)
                        pulse(0);
                    pulse(1);
                end
                else
                    // frames for a write, gaps for a space; bounded if no stop ever comes
                    while (!stopped && n < 64)
                    begin
                        pulse(motion_op == `TFCS_OP_WRITE ? 0 : 1);
                        n = n + 1;
                    end
            end
        end
    end
endmodule

/* tb/test_tape_formatter_command_status.sv */
`timescale 1ns/10ps
`include "tfcs_map.vh"
module test_tape_formatter_command_status;
    localparam [7:0] TYPE = 8'h3C; // arbitrary type code
    reg         ref_clk, rst_b, cmd_wr, tc_wr, fc_wr, ata_clr, tp_present, tp_online, tp_wlock;
    reg  [5:0]  cmd_word;
    reg  [15:0] tc_wdata, fc_wdata, err_flags, d;
    reg  [7:0]  wr_char;
    reg  [3:0]  pace, read_len;
    reg  [1:0]  ev_d;
    wire [3:0]  tp_ev;
    wire        tp_bot, attention_line, motion_go, motion_stop, drive_clear, char_parity;
    wire [15:0] drive_status, drive_type, tape_control, frame_count;
    wire [2:0]  motion_op;
    integer     errors, num_checks, i, k, exp_n, ev_cnt, seed;

    tfcs_top #(.TYPE_CODE(TYPE)) uut
    (
        .ref_clk, .rst_b, .cmd_wr, .cmd_word, .tc_wr, .tc_wdata, .fc_wr, .fc_wdata, .ata_clr, .err_flags,
        .wr_char, .tp_present, .tp_online, .tp_wlock, .tp_bot, .tp_eot(1'b0), .tp_mark(tp_ev[2]),
        .tp_frame(tp_ev[0]), .tp_gap(tp_ev[1]), .tp_rew_done(tp_ev[3]), .drive_status, .drive_type,
        .tape_control, .frame_count, .attention_line, .motion_op, .motion_go, .motion_stop, .drive_clear,
        .char_parity
    );
    tfcs_transport_model u_tp (.ref_clk, .motion_op, .motion_go, .motion_stop, .pace, .read_len, .tp_bot, .tp_ev);

    // 100 ns period
    always #50 ref_clk = ~ref_clk;

    // counts frame and gap events offered by the transport
    always @(posedge ref_clk)
    begin
        ev_d <= tp_ev[1:0];
        if ((tp_ev[1:0] & ~ev_d) != 2'b00)
            ev_cnt <= ev_cnt + 1;
    end

    task check(input string what, input [15:0] exp, input [15:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("unexpected %0s: expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task final_report;
    begin
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    // one-cycle strobe on the command, control, count or attention-clear port
    task poke(input integer s, input [15:0] v);
    begin
        @(negedge ref_clk);
        cmd_word = v[5:0];
        tc_wdata = v;
        fc_wdata = v;
        {cmd_wr, tc_wr, fc_wr, ata_clr} = 4'h8 >> s;
        @(negedge ref_clk);
        {cmd_wr, tc_wr, fc_wr, ata_clr} = 4'h0;
    end
    endtask

    // status bit b, or the stop pulse for b of 16, under a bounded wait
    task wait_for(input integer b);
        integer t;
    begin
        t = 0;
        while (((b == 16) ? motion_stop : drive_status[b]) !== 1'b1 && t < 3000)
        begin
            @(negedge ref_clk);
            t = t + 1;
        end
        if (t == 3000)
        begin
            errors = errors + 1;
            $display("unexpected timeout on %0d", b);
            final_report;
        end
    end
    endtask

    initial
    begin
        {ref_clk, rst_b, cmd_wr, tc_wr, fc_wr, ata_clr, tp_wlock} = 7'h00;
        {tp_present, tp_online, cmd_word, tc_wdata, fc_wdata, err_flags, wr_char} = {2'b11, 62'h0};
        {errors, num_checks, ev_cnt, ev_d, pace, read_len} = {96'h0, 2'b00, 4'h3, 4'h2};
        seed = $urandom(77);
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("type", {8'h44, TYPE}, drive_type);
        check("status", 16'h1080, drive_status & 16'h1880);
        poke(0, `TFCS_CMD_REWIND);
        wait_for(`TFCS_DS_SSC);
        repeat (2) @(posedge ref_clk);
        #1 check("rewind", 16'h90C2, drive_status & 16'hB0C2);
        check("attention_line", 16'h1, attention_line);
        poke(3, 16'h0);
        repeat (3) @(posedge ref_clk);
        #1 check("attention_line clr", 16'h0, attention_line);
        // parity selection over both densities and both parity settings
        for (i = 0; i < 4; i = i + 1)
        begin
            d = {5'h00, i[1] ? 3'h4 : 3'($urandom % 4), 4'($urandom), i[0], 3'h0};
            poke(1, d);
            check("tc", d & 16'h07FF, tape_control);
            wr_char = $urandom;
            @(posedge ref_clk);
            #1 check("parity", (i == 1) ? ^wr_char : ~^wr_char, char_parity);
        end
        // writes in both densities, PE then NRZI, a refused read in mid-record
        for (k = 0; k < 2; k = k + 1)
        begin
            pace = 2 + $urandom % 5;
            exp_n = (1 + $urandom % 3) * (k ? 4 : 2);
            poke(1, k ? 16'h0000 : 16'h0400);
            poke(2, exp_n);
            ev_cnt = 0;
            poke(0, `TFCS_CMD_WRITE);
            repeat (3) @(negedge ref_clk);
            poke(0, `TFCS_CMD_READ_FWD);
            check("refused op", `TFCS_OP_WRITE, motion_op);
            wait_for(16);
            repeat (6) @(posedge ref_clk);
            #1 check("frames", exp_n, ev_cnt);
            check("fc end", 16'h0, frame_count);
            check("idb", k ? 16'h0 : 16'h1, drive_status[4]);
        end
        // read forward with a stale count left in the register
        read_len = 1 + $urandom % 8;
        poke(2, 16'($urandom));
        poke(0, `TFCS_CMD_READ_FWD);
        wait_for(16);
        check("read fc", read_len, frame_count);
        tp_wlock = 1'b1;
        repeat (5) @(negedge ref_clk);
        check("wlock", 16'h1, drive_status[11]);
        poke(0, `TFCS_CMD_WRITE);
        repeat (3) @(negedge ref_clk);
        check("locked op", `TFCS_OP_READ_FWD, motion_op);
        tp_wlock = 1'b0;
        // space over a random number of records
        k = 1 + $urandom % 4;
        poke(2, 16'h0 - k);
        ev_cnt = 0;
        poke(0, `TFCS_CMD_SPACE_FWD);
        wait_for(16);
        repeat (6) @(posedge ref_clk);
        #1 check("gaps", k, ev_cnt);
        check("space fc", 16'h0, frame_count);
        poke(0, `TFCS_CMD_MARK);
        wait_for(16);
        repeat (3) @(negedge ref_clk);
        check("tm", 16'h1, drive_status[2]);
        err_flags = 16'h1 << ($urandom % 16);
        repeat (4) @(negedge ref_clk);
        check("err", 16'h1, drive_status[14]);
        err_flags = 16'h0;
        poke(0, `TFCS_CMD_DCLR);
        check("dclr", 16'h1, drive_clear);
        repeat (3) @(posedge ref_clk);
        #1 check("dclr st", 16'h1080, drive_status & 16'hB0D4);
        final_report;
    end
endmodule
